//--- dtsm_cpu_model.sv
// CPU side model issuing register writes and reads on the register bus
`timescale 1ns/10ps
module dtsm_cpu_model import dtsm_pkg::*; (
	input wire logic clk,
	output logic [7:0] sfr_addr,
	output logic [7:0] sfr_wdata,
	output logic sfr_wr,
	output logic sfr_rd,
	input wire logic [7:0] sfr_rdata
);
	initial begin
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
	end
	// One-cycle strobe; data inverted after release so stale values never match
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
		sfr_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		d = sfr_rdata;
	endtask : rd
endmodule : dtsm_cpu_model

//--- dtsm_params.svh
// Register offsets, field positions, reset values and divider counts of the dual timer
`ifndef DTSM_PARAMS_SVH
`define DTSM_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define DTSM_OFS_CTRL 8'h88
`define DTSM_OFS_MODE 8'h89
`define DTSM_OFS_FIR_LO 8'h8A
`define DTSM_OFS_SEC_LO 8'h8B
`define DTSM_OFS_FIR_HI 8'h8C
`define DTSM_OFS_SEC_HI 8'h8D
`define DTSM_OFS_CLK 8'h8E

// ****************************************
// Control/status fields
// ****************************************
`define DTSM_B_SEC_OVF 7
`define DTSM_B_SEC_RUN 6
`define DTSM_B_FIR_OVF 5
`define DTSM_B_FIR_RUN 4
`define DTSM_B_X0_FLAG 1
`define DTSM_B_X0_TYPE 0

// ****************************************
// Mode and clock fields
// ****************************************
`define DTSM_B_SEC_GATE 7
`define DTSM_B_SEC_CSEL 6
`define DTSM_B_SEC_MODE 4
`define DTSM_B_FIR_GATE 3
`define DTSM_B_FIR_CSEL 2
`define DTSM_B_FIR_MODE 0
`define DTSM_B_SEC_CLKSEL 4
`define DTSM_B_FIR_CLKSEL 3
`define DTSM_B_PRESC 0
`define DTSM_CLK_WMASK 8'h1B
`define DTSM_RST_REG 8'h00

// ****************************************
// Pins and prescaler
// ****************************************
`define DTSM_NSYNC 5
`define DTSM_NPREV 4
`define DTSM_SYNC_RST 5'h1F
`define DTSM_PIN_IRQ0 0
`define DTSM_PIN_CNT0 2
`define DTSM_PIN_CNT1 3
`define DTSM_PIN_EXTCLK 4
`define DTSM_DIV_12 6'h0C
`define DTSM_DIV_4 6'h04
`define DTSM_DIV_48 6'h30
`define DTSM_EXT_LAST 3'h7

`endif

//--- dtsm_pkg.sv
// Types of the dual timer block
`include "dtsm_params.svh"
package dtsm_pkg;
	typedef enum logic [1:0] {DTSM_M13, DTSM_M16, DTSM_M8RL, DTSM_MSPLIT} dtsm_mode_t;
	typedef struct packed {
		logic [`DTSM_NSYNC-1:0] s1;
		logic [`DTSM_NSYNC-1:0] s2;
	} dtsm_sync_t;
	typedef struct packed {
		logic [5:0] cnt;
		logic [2:0] ecnt;
		logic ext_prev;
		logic tick;
	} dtsm_presc_t;
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] mode;
		logic [7:0] clk;
		logic [7:0] tl0;
		logic [7:0] th0;
		logic [7:0] tl1;
		logic [7:0] th1;
		logic [7:0] rdata;
		logic [`DTSM_NPREV-1:0] prev;
		logic pulse;
	} dtsm_state_t;
endpackage : dtsm_pkg

//--- dtsm_presc.sv
// Shared prescaler: system clock by 12, 4, 48 or external clock by 8
`timescale 1ns/10ps
`include "dtsm_params.svh"
module dtsm_presc import dtsm_pkg::*; (
	input wire logic clk,
	input wire logic srst,
	input wire logic [1:0] sel,
	input wire logic ext_s,
	output logic tick
);
	dtsm_presc_t q;
	dtsm_presc_t n;
	logic [5:0] lim;

	always_comb begin
		case (sel)
			2'h0: lim = `DTSM_DIV_12;
			2'h1: lim = `DTSM_DIV_4;
			default: lim = `DTSM_DIV_48;
		endcase
	end

	always_comb begin
		n = q;
		n.tick = 1'b0;
		n.ext_prev = ext_s;
		if (sel == 2'h3) begin
			// Synchronised rising edges of the external clock, one tick per eight
			if (ext_s & ~q.ext_prev) begin //RULE_17
				n.ecnt = q.ecnt + 3'h1;
				n.tick = (q.ecnt == `DTSM_EXT_LAST); //RULE_16
			end
		end else if (q.cnt >= lim - 6'h01) begin
			n.cnt = 6'h00;
			n.tick = 1'b1; //RULE_16
		end else begin
			n.cnt = q.cnt + 6'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign tick = q.tick;
endmodule : dtsm_presc

//--- dtsm_sync.sv
// Two-stage synchroniser for the pin inputs
`timescale 1ns/10ps
`include "dtsm_params.svh"
module dtsm_sync import dtsm_pkg::*; (
	input wire logic clk,
	input wire logic srst,
	input wire logic [`DTSM_NSYNC-1:0] din,
	output logic [`DTSM_NSYNC-1:0] dout
);
	dtsm_sync_t q;
	dtsm_sync_t n;

	always_comb begin
		n.s1 = din;
		n.s2 = q.s1;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q <= {`DTSM_SYNC_RST, `DTSM_SYNC_RST};
		end else begin
			q <= n;
		end
	end

	assign dout = q.s2;
endmodule : dtsm_sync

//--- dtsm_top.sv
// Dual timer with split mode, control/status, mode and prescaler registers
`timescale 1ns/10ps
`include "dtsm_params.svh"
// Function
// RULE_01: Split mode: low byte is 8-bit counter using first timer's controls.
// RULE_02: Split mode: high byte times only, runs on second run bit, sets second flag.
// RULE_03: Split mode: second timer never counts pins nor sets its flag; pulse remains.
// RULE_04: Split mode: second timer runs in modes 0-2, halts in mode 3.
// RULE_05: Overflow flags set by hardware, cleared by software or vectoring.
// RULE_06: Run bits enable their timer when 1, stop it when 0.
// RULE_07: External flags set on edge/level; vectoring clears only edge-type flags.
// RULE_08: External flag is inverse of active-low input.
// RULE_09: Type bit: 0 level active-low, 1 falling edge.
// RULE_10: Gate bit 1 also needs external interrupt input high to run.
// RULE_11: Counter select 1 counts falling edges on count pin.
// RULE_12: Second mode field: 13-bit, 16-bit, 8-bit reload, inactive.
// RULE_13: First mode field same, but code 3 is split mode.
// RULE_14: Second clock select: prescaled when 0, system clock when 1.
// RULE_15: First clock select: prescaled when 0, system clock when 1.
// RULE_16: Prescaler: sysclk/12, /4, /48, or external clock/8.
// RULE_17: External clock is synchronised; must not exceed system clock.
// RULE_18: Unused clock register bits read zero, writes ignored.
// RULE_19: Each count is two 8-bit registers, low and high.
// RULE_20: 13-bit mode sets overflow flag on wrap from all ones.
// RULE_21: Reload mode: low byte wraps, reloads from high byte, flag set.
// RULE_22: Count pins hold each level two clocks; events up to quarter rate.
// RULE_23: Setting run bit keeps the count as it is.
// RULE_24: Split counters wrap from 0xFF to zero and set their flag.
// RULE_25: Control, mode and clock registers reset to zero.
module dtsm_top import dtsm_pkg::*; (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic [7:0] SFR_ADDR,
	input wire logic [7:0] SFR_WDATA,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	output logic [7:0] SFR_RDATA,
	input wire logic FIRST_OVF_ACK,
	input wire logic SECOND_OVF_ACK,
	input wire logic EXT_IRQ0_ACK,
	input wire logic EXT_IRQ1_ACK,
	input wire logic EXT_IRQ0_INPUT_N,
	input wire logic EXT_IRQ1_INPUT_N,
	input wire logic FIRST_COUNT_PIN,
	input wire logic SECOND_COUNT_PIN,
	input wire logic EXT_CLK,
	output logic FIRST_OVERFLOW_FLAG,
	output logic SECOND_OVERFLOW_FLAG,
	output logic EXT_IRQ0_FLAG,
	output logic EXT_IRQ1_FLAG,
	output logic SECOND_OVF_PULSE
);
	// ****************************************
	// State and decode
	// ****************************************
	dtsm_state_t q;
	dtsm_state_t n;
	logic [`DTSM_NSYNC-1:0] pin_s;
	logic [`DTSM_NPREV-1:0] fall;
	logic ps_tick;
	dtsm_mode_t mode0;
	dtsm_mode_t mode1;
	logic split;
	logic tick0;
	logic tick_hi;
	logic tick1;
	logic run0;
	logic run1;
	logic hi_run;
	logic wr_ctrl;
	logic wr_mode;
	logic wr_clk;
	logic wr_tl0;
	logic wr_th0;
	logic wr_tl1;
	logic wr_th1;
	logic [1:0] x_ack;

	dtsm_sync u_sync (
		.clk(CLK),
		.srst(SRST),
		.din({EXT_CLK, SECOND_COUNT_PIN, FIRST_COUNT_PIN, EXT_IRQ1_INPUT_N, EXT_IRQ0_INPUT_N}),
		.dout(pin_s)
	);

	dtsm_presc u_presc (
		.clk(CLK),
		.srst(SRST),
		.sel(q.clk[`DTSM_B_PRESC +: 2]),
		.ext_s(pin_s[`DTSM_PIN_EXTCLK]),
		.tick(ps_tick)
	);

	assign fall = q.prev & ~pin_s[`DTSM_NPREV-1:0]; //RULE_11
	assign mode0 = dtsm_mode_t'(q.mode[`DTSM_B_FIR_MODE +: 2]); //RULE_13
	assign mode1 = dtsm_mode_t'(q.mode[`DTSM_B_SEC_MODE +: 2]); //RULE_12
	assign split = (mode0 == DTSM_MSPLIT);
	assign tick_hi = q.clk[`DTSM_B_FIR_CLKSEL] | ps_tick; //RULE_15
	assign tick0 = q.mode[`DTSM_B_FIR_CSEL] ? fall[`DTSM_PIN_CNT0] : tick_hi; //RULE_11
	// Pin counting for the second timer is cut off in split mode
	assign tick1 = (q.mode[`DTSM_B_SEC_CSEL] & ~split) ? fall[`DTSM_PIN_CNT1] :
		(q.clk[`DTSM_B_SEC_CLKSEL] | ps_tick); //RULE_14 RULE_03
	assign run0 = q.ctrl[`DTSM_B_FIR_RUN] & (~q.mode[`DTSM_B_FIR_GATE] | pin_s[`DTSM_PIN_IRQ0]); //RULE_06 RULE_10
	assign run1 = (mode1 != DTSM_MSPLIT) & (split | q.ctrl[`DTSM_B_SEC_RUN])
		& (~q.mode[`DTSM_B_SEC_GATE] | pin_s[`DTSM_PIN_IRQ0 + 1]); //RULE_04 RULE_06 RULE_10
	assign hi_run = split & q.ctrl[`DTSM_B_SEC_RUN]; //RULE_02
	assign wr_ctrl = SFR_WR & (SFR_ADDR == `DTSM_OFS_CTRL);
	assign wr_mode = SFR_WR & (SFR_ADDR == `DTSM_OFS_MODE);
	assign wr_clk = SFR_WR & (SFR_ADDR == `DTSM_OFS_CLK);
	assign wr_tl0 = SFR_WR & (SFR_ADDR == `DTSM_OFS_FIR_LO);
	assign wr_th0 = SFR_WR & (SFR_ADDR == `DTSM_OFS_FIR_HI);
	assign wr_tl1 = SFR_WR & (SFR_ADDR == `DTSM_OFS_SEC_LO);
	assign wr_th1 = SFR_WR & (SFR_ADDR == `DTSM_OFS_SEC_HI);
	assign x_ack = {EXT_IRQ1_ACK, EXT_IRQ0_ACK};

	// ****************************************
	// Count step: returns {overflow, high, low}
	// ****************************************
	function automatic logic [16:0] step(input dtsm_mode_t m, input logic [7:0] lo, input logic [7:0] hi);
		logic [13:0] s13;
		logic [16:0] r;
		s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
		case (m)
			DTSM_M13: r = {s13[13], s13[12:5], lo[7:5], s13[4:0]}; //RULE_20
			DTSM_M16: r = {1'b0, hi, lo} + 17'h00001;
			DTSM_M8RL: r = (lo == 8'hFF) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01}; //RULE_21
			default: r = {1'b0, hi, lo};
		endcase
		return r;
	endfunction : step

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic set_tf0;
		logic set_tf1;
		logic ovf1;
		logic [8:0] lo9;
		logic [8:0] hi9;
		set_tf0 = 1'b0;
		set_tf1 = 1'b0;
		ovf1 = 1'b0;
		lo9 = {1'b0, q.tl0} + 9'h001;
		hi9 = {1'b0, q.th0} + 9'h001;
		n = q;
		n.pulse = 1'b0;
		n.prev = pin_s[`DTSM_NPREV-1:0];
		// Counting continues from the held value; nothing reloads on run
		if (split) begin
			if (run0 & tick0) begin
				n.tl0 = lo9[7:0]; //RULE_01 RULE_24
				set_tf0 = lo9[8];
			end
			if (hi_run & tick_hi) begin
				n.th0 = hi9[7:0]; //RULE_02 RULE_24
				set_tf1 = hi9[8];
			end
		end else if (run0 & tick0) begin
			{set_tf0, n.th0, n.tl0} = step(mode0, q.tl0, q.th0); //RULE_23
		end
		if (run1 & tick1) begin
			{ovf1, n.th1, n.tl1} = step(mode1, q.tl1, q.th1);
			n.pulse = ovf1; //RULE_03
			set_tf1 = set_tf1 | (ovf1 & ~split); //RULE_03
		end
		// Register writes win over counting in the same cycle
		if (wr_ctrl) begin
			n.ctrl = SFR_WDATA;
		end
		if (wr_mode) begin
			n.mode = SFR_WDATA;
		end
		if (wr_clk) begin
			n.clk = SFR_WDATA & `DTSM_CLK_WMASK; //RULE_18
		end
		if (wr_tl0) begin
			n.tl0 = SFR_WDATA; //RULE_19
		end
		if (wr_th0) begin
			n.th0 = SFR_WDATA; //RULE_19
		end
		if (wr_tl1) begin
			n.tl1 = SFR_WDATA; //RULE_19
		end
		if (wr_th1) begin
			n.th1 = SFR_WDATA; //RULE_19
		end
		// Vectoring clears, hardware set wins
		if (FIRST_OVF_ACK) begin
			n.ctrl[`DTSM_B_FIR_OVF] = 1'b0; //RULE_05
		end
		if (SECOND_OVF_ACK) begin
			n.ctrl[`DTSM_B_SEC_OVF] = 1'b0; //RULE_05
		end
		n.ctrl[`DTSM_B_FIR_OVF] = n.ctrl[`DTSM_B_FIR_OVF] | set_tf0; //RULE_05
		n.ctrl[`DTSM_B_SEC_OVF] = n.ctrl[`DTSM_B_SEC_OVF] | set_tf1; //RULE_05
		for (int i = 0; i < 2; i++) begin
			if (!q.ctrl[`DTSM_B_X0_TYPE + 2 * i]) begin
				n.ctrl[`DTSM_B_X0_FLAG + 2 * i] = ~pin_s[`DTSM_PIN_IRQ0 + i]; //RULE_08 RULE_09
			end else begin
				if (x_ack[i]) begin
					n.ctrl[`DTSM_B_X0_FLAG + 2 * i] = 1'b0; //RULE_07
				end
				n.ctrl[`DTSM_B_X0_FLAG + 2 * i] = n.ctrl[`DTSM_B_X0_FLAG + 2 * i]
					| fall[`DTSM_PIN_IRQ0 + i]; //RULE_07 RULE_09
			end
		end
		if (SFR_RD) begin
			case (SFR_ADDR)
				`DTSM_OFS_CTRL: n.rdata = q.ctrl;
				`DTSM_OFS_MODE: n.rdata = q.mode;
				`DTSM_OFS_CLK: n.rdata = q.clk; //RULE_18
				`DTSM_OFS_FIR_LO: n.rdata = q.tl0;
				`DTSM_OFS_FIR_HI: n.rdata = q.th0;
				`DTSM_OFS_SEC_LO: n.rdata = q.tl1;
				`DTSM_OFS_SEC_HI: n.rdata = q.th1;
				default: n.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			q <= '0; //RULE_25
		end else begin
			q <= n;
		end
	end

	assign SFR_RDATA = q.rdata;
	assign FIRST_OVERFLOW_FLAG = q.ctrl[`DTSM_B_FIR_OVF];
	assign SECOND_OVERFLOW_FLAG = q.ctrl[`DTSM_B_SEC_OVF];
	assign EXT_IRQ0_FLAG = q.ctrl[`DTSM_B_X0_FLAG];
	assign EXT_IRQ1_FLAG = q.ctrl[`DTSM_B_X0_FLAG + 2];
	assign SECOND_OVF_PULSE = q.pulse;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	sequence s_lo_wrap;
		split && run0 && tick0 && q.tl0 == 8'hFF && !SFR_WR;
	endsequence
	sequence s_hi_wrap;
		hi_run && tick_hi && q.th0 == 8'hFF && !SFR_WR;
	endsequence
	sequence s_quiet1;
		!SFR_WR && !(hi_run && tick_hi && q.th0 == 8'hFF) && !SECOND_OVF_ACK;
	endsequence
	sequence s_sec_wrap;
		mode1 == DTSM_M13 && run1 && tick1 && q.th1 == 8'hFF && q.tl1[4:0] == 5'h1F && !SFR_WR;
	endsequence

	clk_unused_zero_a: assert property ((q.clk & ~`DTSM_CLK_WMASK) == 8'h00) //RULE_18
		else $error("unused clock bits set");
	split_lo_wrap_a: assert property (s_lo_wrap |=> q.tl0 == 8'h00 && FIRST_OVERFLOW_FLAG) //RULE_24
		else $error("split low byte wrap wrong");
	split_hi_flag_a: assert property (s_hi_wrap |=> q.th0 == 8'h00 && SECOND_OVERFLOW_FLAG) //RULE_02
		else $error("split high byte did not set second flag");
	split_no_flag_a: assert property (split && !SECOND_OVERFLOW_FLAG ##0 s_quiet1 //RULE_03
		|=> !SECOND_OVERFLOW_FLAG)
		else $error("second timer set its flag in split mode");
	inactive_halt_a: assert property (mode1 == DTSM_MSPLIT && !SFR_WR //RULE_04
		|=> $stable(q.tl1) && $stable(q.th1) && !SECOND_OVF_PULSE)
		else $error("second timer counted in mode 3");
	stopped_hold_a: assert property (!q.ctrl[`DTSM_B_FIR_RUN] && !hi_run && !SFR_WR [*2] //RULE_06
		|=> $stable(q.tl0) && $stable(q.th0))
		else $error("first timer counted while stopped");
	reload_step_a: assert property (mode0 == DTSM_M8RL && run0 && tick0 && q.tl0 == 8'hFF && !SFR_WR //RULE_21
		|=> q.tl0 == $past(q.th0) && $stable(q.th0) && FIRST_OVERFLOW_FLAG)
		else $error("auto reload wrong");
	wrap13_flag_a: assert property (mode0 == DTSM_M13 && run0 && tick0 && q.th0 == 8'hFF //RULE_20
		&& q.tl0[4:0] == 5'h1F && !SFR_WR |=> FIRST_OVERFLOW_FLAG && q.th0 == 8'h00)
		else $error("13-bit wrap wrong");
	level_flag_a: assert property (!q.ctrl[`DTSM_B_X0_TYPE] && !SFR_WR //RULE_08
		|=> EXT_IRQ0_FLAG == !$past(pin_s[`DTSM_PIN_IRQ0]))
		else $error("level flag not inverse of input");
	edge_ack_a: assert property (q.ctrl[`DTSM_B_X0_TYPE] && EXT_IRQ0_ACK && !fall[`DTSM_PIN_IRQ0] && !SFR_WR //RULE_07
		|=> !EXT_IRQ0_FLAG)
		else $error("edge flag not cleared by vectoring");
	gate_block_a: assert property (q.mode[`DTSM_B_FIR_GATE] && !pin_s[`DTSM_PIN_IRQ0] && !hi_run && !SFR_WR //RULE_10
		|=> $stable(q.tl0) && $stable(q.th0))
		else $error("gated timer counted");
	wr_low_a: assert property (wr_tl0 |=> q.tl0 == $past(SFR_WDATA)) //RULE_19
		else $error("first low byte write lost");
	wr_high_a: assert property (wr_th1 |=> q.th1 == $past(SFR_WDATA)) //RULE_19
		else $error("second high byte write lost");
	rd_clk_a: assert property (SFR_RD && SFR_ADDR == `DTSM_OFS_CLK //RULE_18
		|=> SFR_RDATA == $past(q.clk))
		else $error("clock register read wrong");
	ack_clear_a: assert property (FIRST_OVF_ACK && !(run0 && tick0) && !SFR_WR //RULE_05
		|=> !FIRST_OVERFLOW_FLAG)
		else $error("first flag not cleared by vectoring");
	sec_ack_clear_a: assert property (SECOND_OVF_ACK && !(hi_run && tick_hi) && !(run1 && tick1) && !SFR_WR //RULE_05
		|=> !SECOND_OVERFLOW_FLAG)
		else $error("second flag not cleared by vectoring");
	level_flag1_a: assert property (!q.ctrl[`DTSM_B_X0_TYPE + 2] && !SFR_WR //RULE_08
		|=> EXT_IRQ1_FLAG == !$past(pin_s[`DTSM_PIN_IRQ0 + 1]))
		else $error("second level flag not inverse of input");
	edge_set_a: assert property (q.ctrl[`DTSM_B_X0_TYPE] && fall[`DTSM_PIN_IRQ0] |=> EXT_IRQ0_FLAG) //RULE_07
		else $error("falling edge did not set flag");
	sec_pulse_a: assert property (s_sec_wrap |=> SECOND_OVF_PULSE) //RULE_03
		else $error("second timer overflow pulse missing");
	cnt_idle_a: assert property (q.mode[`DTSM_B_FIR_CSEL] && !split && !fall[`DTSM_PIN_CNT0] && !SFR_WR //RULE_11
		|=> $stable(q.tl0) && $stable(q.th0))
		else $error("counter moved without pin edge");
endmodule : dtsm_top

//--- tb_top.sv
// Testbench of the dual timer: registers, modes, split mode, pins and prescaler
`timescale 1ns/10ps
`include "dtsm_params.svh"
module tb_top import dtsm_pkg::*; ;
	typedef struct packed {
		logic [7:0] a;
		logic we;
		logic [7:0] d;
		logic [7:0] e;
	} dtsm_row_t;
	localparam logic [7:0] ctl = `DTSM_OFS_CTRL;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic ext_clk = 1'b0;
	logic [3:0] acks = 4'h0;
	logic [1:0] irq_n = 2'h3;
	logic [1:0] cnt = 2'h3;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d;
	logic sfr_wr, sfr_rd, f0, f1, x0, x1, pulse;
	int failures = 0;
	int total_checks = 0;
	int n;
	int divs [4] = '{12, 4, 48, 36};
	dtsm_row_t rows [11] = '{'{8'h88, 1'b0, 8'h00, 8'h00}, '{8'h89, 1'b0, 8'h00, 8'h00},
		'{8'h8E, 1'b0, 8'h00, 8'h00}, '{8'h8A, 1'b0, 8'h00, 8'h00}, '{8'h87, 1'b1, 8'h5A, 8'h00},
		'{8'h8E, 1'b1, 8'hFF, 8'h1B}, '{8'h89, 1'b1, 8'hA5, 8'hA5}, '{8'h8A, 1'b1, 8'h3C, 8'h3C},
		'{8'h8B, 1'b1, 8'hC3, 8'hC3}, '{8'h8C, 1'b1, 8'h5A, 8'h5A}, '{8'h8D, 1'b1, 8'hA5, 8'hA5}};
	always #5 clk = ~clk;
	// Slower than the system clock
	always #23 ext_clk = ~ext_clk;
	dtsm_cpu_model cpu (.clk(clk), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata));
	dtsm_top dut (.CLK(clk), .SRST(srst), .SFR_ADDR(sfr_addr), .SFR_WDATA(sfr_wdata), .SFR_WR(sfr_wr),
		.SFR_RD(sfr_rd), .SFR_RDATA(sfr_rdata), .FIRST_OVF_ACK(acks[0]), .SECOND_OVF_ACK(acks[1]),
		.EXT_IRQ0_ACK(acks[2]), .EXT_IRQ1_ACK(acks[3]), .EXT_IRQ0_INPUT_N(irq_n[0]),
		.EXT_IRQ1_INPUT_N(irq_n[1]), .FIRST_COUNT_PIN(cnt[0]), .SECOND_COUNT_PIN(cnt[1]),
		.EXT_CLK(ext_clk), .FIRST_OVERFLOW_FLAG(f0), .SECOND_OVERFLOW_FLAG(f1), .EXT_IRQ0_FLAG(x0),
		.EXT_IRQ1_FLAG(x1), .SECOND_OVF_PULSE(pulse));
	// ****
	// Helpers
	// ****
	task automatic chk8(input string s, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
		end
	endtask : chk8
	task automatic chk1(input string s, input logic g, input logic e);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s exp %b got %b", s, e, g);
		end
	endtask : chk1
	function automatic logic sig(input int s);
		case (s)
			0: return f0;
			1: return f1;
			2: return x0;
			3: return x1;
			default: return pulse;
		endcase
	endfunction : sig
	// Cycles until the chosen output is high, bounded
	task automatic wait_sig(input int s);
		n = 0;
		while (sig(s) !== 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
	endtask : wait_sig
	task automatic idle(input int c);
		repeat (c) @(negedge clk);
	endtask : idle
	task automatic ack(input int s);
		@(negedge clk);
		acks[s] = 1'b1;
		@(negedge clk);
		acks = 4'h0;
	endtask : ack
	task automatic arm(input logic [7:0] m, input logic [7:0] c, input logic [7:0] lo, input logic [7:0] hi);
		cpu.wr(ctl, 8'h00);
		cpu.wr(`DTSM_OFS_MODE, m);
		cpu.wr(`DTSM_OFS_CLK, c);
		cpu.wr(`DTSM_OFS_FIR_LO, lo);
		cpu.wr(`DTSM_OFS_FIR_HI, hi);
	endtask : arm
	task automatic finish_test;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test
	// ****
	// Tests
	// ****
	initial begin
		#100000;
		failures++;
		finish_test();
	end
	initial begin
		repeat (12) @(negedge clk);
		srst = 1'b0;
		foreach (rows[i]) begin
			if (rows[i].we) cpu.wr(rows[i].a, rows[i].d);
			cpu.rd(rows[i].a, d);
			chk8($sformatf("reg %h", rows[i].a), rows[i].e, d);
		end
		arm(8'h00, 8'h08, 8'h1E, 8'hFF);
		idle(10);
		cpu.rd(`DTSM_OFS_FIR_LO, d);
		chk8("stopped", 8'h1E, d);
		cpu.wr(ctl, 8'h10);
		wait_sig(0);
		chk1("m13 ovf", n <= 6, 1'b1);
		ack(0);
		chk1("ack0", f0, 1'b0);
		arm(8'h02, 8'h08, 8'hFE, 8'h80);
		cpu.wr(ctl, 8'h10);
		wait_sig(0);
		cpu.wr(ctl, 8'h00);
		cpu.rd(`DTSM_OFS_FIR_HI, d);
		chk8("reload hi", 8'h80, d);
		cpu.rd(`DTSM_OFS_FIR_LO, d);
		chk1("reload lo", d >= 8'h80 && d < 8'h90, 1'b1);
		arm(8'h33, 8'h18, 8'hFE, 8'hF0);
		cpu.wr(`DTSM_OFS_SEC_LO, 8'h1F);
		cpu.wr(`DTSM_OFS_SEC_HI, 8'hFF);
		cpu.wr(`DTSM_OFS_MODE, 8'h03);
		wait_sig(4);
		chk1("split sec pulse", n <= 6, 1'b1);
		cpu.wr(ctl, 8'h10);
		wait_sig(0);
		chk1("split lo ovf", n <= 6, 1'b1);
		chk1("split sec flag", f1, 1'b0);
		cpu.rd(`DTSM_OFS_FIR_HI, d);
		chk8("split hi idle", 8'hF0, d);
		cpu.wr(ctl, 8'h50);
		wait_sig(1);
		chk1("split hi ovf", n >= 12 && n <= 24, 1'b1);
		ack(1);
		chk1("ack1", f1, 1'b0);
		cpu.wr(`DTSM_OFS_MODE, 8'h33);
		cpu.wr(`DTSM_OFS_SEC_LO, 8'h00);
		idle(10);
		cpu.rd(`DTSM_OFS_SEC_LO, d);
		chk8("split sec halt", 8'h00, d);
		arm(8'h05, 8'h08, 8'hFE, 8'hFF);
		cpu.wr(ctl, 8'h10);
		for (int k = 0; k < 2; k++) begin
			chk1("cnt early", f0, 1'b0);
			cnt[0] = 1'b0;
			idle(4);
			cnt[0] = 1'b1;
			idle(4);
		end
		wait_sig(0);
		chk1("cnt ovf", n <= 6, 1'b1);
		irq_n[0] = 1'b0;
		arm(8'h09, 8'h08, 8'hFE, 8'hFF);
		cpu.wr(ctl, 8'h10);
		idle(20);
		chk1("gate hold", f0, 1'b0);
		chk1("lvl flag", x0, 1'b1);
		ack(2);
		chk1("lvl ack", x0, 1'b1);
		irq_n[0] = 1'b1;
		wait_sig(0);
		chk1("gate run", n <= 10, 1'b1);
		idle(4);
		chk1("lvl follow", x0, 1'b0);
		for (int k = 0; k < 2; k++) begin
			cpu.wr(ctl, k ? 8'h04 : 8'h01);
			irq_n[k] = 1'b0;
			wait_sig(2 + k);
			chk1("edge set", n <= 6, 1'b1);
			irq_n[k] = 1'b1;
			idle(6);
			chk1("edge hold", sig(2 + k), 1'b1);
			ack(2 + k);
			chk1("edge ack", sig(2 + k), 1'b0);
		end
		foreach (divs[i]) begin
			arm(8'h01, {6'h00, 2'(i)}, 8'hFE, 8'hFF);
			cpu.wr(ctl, 8'h10);
			wait_sig(0);
			chk1("presc", n + 2 > divs[i] && n <= 2 * divs[i] + 8, 1'b1);
		end
		finish_test();
	end
endmodule : tb_top
